// ===== logic/ssr_pkg.sv
package ssr_pkg;

  localparam int          SSR_AW            = 5;
  // register indices on the plain port (byte offsets)
  localparam logic [4:0]  SSR_OFF_DATA      = 5'h18;
  localparam logic [4:0]  SSR_OFF_STAT1     = 5'h16;
  localparam logic [4:0]  SSR_OFF_STAT2     = 5'h17;
  localparam logic [4:0]  SSR_OFF_RATE      = 5'h19;
  localparam logic [4:0]  SSR_OFF_CTRL2     = 5'h13;
  localparam logic [4:0]  SSR_OFF_CTRL3     = 5'h14;
  localparam logic [4:0]  SSR_OFF_FINE      = 5'h1A;

  // status one bit positions
  localparam int          SSR_S1_TXE        = 7;
  localparam int          SSR_S1_TXC        = 6;
  localparam int          SSR_S1_RXF        = 5;
  localparam int          SSR_S1_IDLE       = 4;
  localparam int          SSR_S1_OVR        = 3;
  localparam int          SSR_S1_NOISE      = 2;
  localparam int          SSR_S1_FRAME      = 1;
  localparam int          SSR_S1_PAR        = 0;
  // status two bit positions
  localparam int          SSR_S2_BRK        = 1;
  localparam int          SSR_S2_BUSY       = 0;
  // control two: interrupt enables at 7..4, receiver enable at 2
  localparam int          SSR_C2_EMPTY_IE   = 7;
  localparam int          SSR_C2_CMPL_IE    = 6;
  localparam int          SSR_C2_FULL_IE    = 5;
  localparam int          SSR_C2_IDLE_IE    = 4;
  localparam int          SSR_C2_RX_EN      = 2;
  // control three
  localparam int          SSR_C3_NINTH      = 7;
  localparam int          SSR_C3_OVR_IE     = 3;
  localparam int          SSR_C3_NOISE_IE   = 2;
  localparam int          SSR_C3_FRAME_IE   = 1;
  localparam int          SSR_C3_PAR_IE     = 0;
  // rate register fields
  localparam int          SSR_RT_LIN        = 6;
  localparam int          SSR_RT_PSC_LSB    = 4;
  localparam int          SSR_RT_DIV_LSB    = 0;

  localparam logic [7:0]  SSR_RST_STAT1     = 8'hC0;
  localparam logic [7:0]  SSR_RST_CTRL      = 8'h00;
  localparam logic [7:0]  SSR_RST_RATE      = 8'h00;
  localparam int          SSR_OVERSAMPLE    = 64;
  localparam int          SSR_FINE_STEPS    = 32;

  typedef struct packed {
    logic       char_done;
    logic       noise;
    logic       frame_err;
    logic       parity_err;
    logic       is_break;
    logic       ninth;
    logic [7:0] data;
  } ssr_rx_evt_t;

endpackage : ssr_pkg

// ===== logic/ssr_rate_div.sv
`timescale 1ns/10ps
module ssr_rate_div
  import ssr_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_srst,
  input  wire logic [1:0] i_psc_sel,
  input  wire logic [2:0] i_div_sel,
  input  wire logic [2:0] i_fine_div,
  input  wire logic [4:0] i_fine_adj,
  output logic            o_tick
);
  // tick per bit period: fbus / (64*bpd*bd*(pd+pdfa/32))
  function automatic logic [3:0] psc_val(input logic [1:0] s);
    case (s)
      2'h0:    psc_val = 4'h1;
      2'h1:    psc_val = 4'h3;
      2'h2:    psc_val = 4'h4;
      default: psc_val = 4'hD;
    endcase
  endfunction : psc_val

  logic [5:0]  fine_cnt_reg;
  logic [4:0]  frame_cnt_reg;
  logic        fine_tick;
  logic [3:0]  pd;
  logic [3:0]  psc_cnt_reg;
  logic [23:0] div_cnt_reg;
  logic [23:0] div_top;
  logic        psc_tick;

  // fine prescaler: pd (or bypass) plus inserted clocks per 32-tick frame
  assign pd = (i_fine_div == 3'h0) ? 4'h1 : {1'b0, i_fine_div} + 4'h1;
  assign fine_tick = (fine_cnt_reg == 6'h00);
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      fine_cnt_reg  <= 6'h00;
      frame_cnt_reg <= 5'h00;
    end else if (fine_tick) begin
      frame_cnt_reg <= frame_cnt_reg + 5'h01;
      fine_cnt_reg  <= {2'h0, pd} - 6'h01 + ((i_fine_div != 3'h0 && frame_cnt_reg < i_fine_adj) ? 6'h01 : 6'h00);
    end else begin
      fine_cnt_reg <= fine_cnt_reg - 6'h01;
    end
  end

  assign psc_tick = fine_tick && (psc_cnt_reg == 4'h0);
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) psc_cnt_reg <= 4'h0;
    else if (fine_tick) psc_cnt_reg <= (psc_cnt_reg == 4'h0) ? psc_val(i_psc_sel) - 4'h1 : psc_cnt_reg - 4'h1;
  end

  assign div_top = 24'(SSR_OVERSAMPLE) << i_div_sel;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      div_cnt_reg <= 24'h000000;
      o_tick      <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (psc_tick) begin
        if (div_cnt_reg >= div_top - 24'h000001) begin
          div_cnt_reg <= 24'h000000;
          o_tick      <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 24'h000001;
        end
      end
    end
  end
endmodule : ssr_rate_div

// ===== logic/ssr_top.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module ssr_top
  import ssr_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_srst,
  input  wire logic [SSR_AW-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  input  wire logic              i_rx_evt_valid,
  input  wire ssr_rx_evt_t       i_rx_evt,
  input  wire logic              i_rx_start_zero,
  input  wire logic              i_rx_false_start,
  input  wire logic              i_rx_idle_char,
  input  wire logic              i_rx_line_high,
  input  wire logic              i_rx_long_char,
  input  wire logic              i_tx_load_ack,
  input  wire logic              i_tx_shifting,
  output logic                   o_tx_load_req,
  output logic      [7:0]        o_tx_data,
  output logic                   o_rate_tick,
  output logic                   o_lin_break_select,
  output logic                   o_rx_enable,
  output logic                   o_tx_irq,
  output logic                   o_rx_irq,
  output logic                   o_err_irq
);
  logic [7:0] stat1_reg;
  logic       brk_reg;
  logic       busy_reg;
  logic [7:0] seen1_reg;
  logic       seen_brk_reg;
  logic [7:0] rx_data_reg;
  logic [7:0] tx_data_reg;
  logic       tx_pending_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl3_reg;
  logic [7:0] rate_reg;
  logic [7:0] fine_reg;
  logic       idle_armed_reg;
  logic       brk_armed_reg;
  logic       rx_en_d_reg;
  logic       rd_stat1;
  logic       rd_stat2;
  logic       rd_data;
  logic       wr_data;
  logic       new_char;
  logic       overrun;
  logic       is_brk;
  logic       idle_set;
  logic [7:0] clr1;
  logic [7:0] set1;

  assign rd_stat1 = i_rd && (i_addr == SSR_OFF_STAT1);
  assign rd_stat2 = i_rd && (i_addr == SSR_OFF_STAT2);
  assign rd_data  = i_rd && (i_addr == SSR_OFF_DATA);
  assign wr_data  = i_wr && (i_addr == SSR_OFF_DATA);

  assign is_brk   = i_rx_evt_valid && i_rx_evt.char_done && i_rx_evt.is_break && brk_armed_reg;
  assign new_char = i_rx_evt_valid && i_rx_evt.char_done && (!i_rx_evt.is_break || brk_armed_reg);
  assign overrun  = new_char && stat1_reg[SSR_S1_RXF] && !is_brk;
  assign idle_set = i_rx_idle_char && idle_armed_reg;

  // clears from the two-access sequences
  always_comb begin
    clr1 = 8'h00;
    if (rd_data) begin
      clr1 = seen1_reg & 8'h3F;
    end
    if (wr_data) begin
      clr1[SSR_S1_TXE] = seen1_reg[SSR_S1_TXE];
    end
  end

  always_comb begin
    set1 = 8'h00;
    set1[SSR_S1_TXE]   = i_tx_load_ack;
    set1[SSR_S1_RXF]   = (new_char && !overrun) || is_brk;
    set1[SSR_S1_IDLE]  = idle_set;
    set1[SSR_S1_OVR]   = overrun;
    set1[SSR_S1_NOISE] = new_char && !overrun && i_rx_evt.noise;
    set1[SSR_S1_FRAME] = (new_char && !overrun && i_rx_evt.frame_err) || is_brk;
    set1[SSR_S1_PAR]   = new_char && !overrun && i_rx_evt.parity_err;
  end

  // status one flags: set wins over clear; TXC is rederived each cycle and the TXE clear forces it to zero
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      stat1_reg <= SSR_RST_STAT1;
    end else begin
      stat1_reg[5:0] <= (stat1_reg[5:0] & ~clr1[5:0]) | set1[5:0];
      stat1_reg[SSR_S1_TXE] <= (stat1_reg[SSR_S1_TXE] & ~clr1[SSR_S1_TXE]) | set1[SSR_S1_TXE];
      stat1_reg[SSR_S1_TXC] <= stat1_reg[SSR_S1_TXE] && !tx_pending_reg && !i_tx_shifting
                               && !clr1[SSR_S1_TXE];
    end
  end

  // record of flags seen at the status reads
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      seen1_reg    <= 8'h00;
      seen_brk_reg <= 1'b0;
    end else begin
      if (rd_stat1) seen1_reg <= stat1_reg;
      else if (rd_data) seen1_reg <= seen1_reg & 8'hC0;
      else if (wr_data) seen1_reg[SSR_S1_TXE] <= 1'b0;
      if (rd_stat2) seen_brk_reg <= brk_reg;
      else if (rd_data) seen_brk_reg <= 1'b0;
    end
  end

  // break flag and its rearm on ones
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      brk_reg       <= 1'b0;
      brk_armed_reg <= 1'b1;
    end else begin
      if (is_brk) brk_reg <= 1'b1;
      else if (rd_data && seen_brk_reg) brk_reg <= 1'b0;
      if (is_brk) brk_armed_reg <= 1'b0;
      else if (i_rx_line_high) brk_armed_reg <= 1'b1;
    end
  end

  // reception in progress
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) busy_reg <= 1'b0;
    else if (i_rx_start_zero) busy_reg <= 1'b1;
    else if (i_rx_false_start || i_rx_idle_char) busy_reg <= 1'b0;
  end

  // idle arming: needs a full character after enable or clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      idle_armed_reg <= 1'b0;
      rx_en_d_reg    <= 1'b0;
    end else begin
      rx_en_d_reg <= ctrl2_reg[SSR_C2_RX_EN];
      if (ctrl2_reg[SSR_C2_RX_EN] && !rx_en_d_reg) idle_armed_reg <= 1'b0;
      else if (set1[SSR_S1_RXF]) idle_armed_reg <= 1'b1;
      else if (idle_set || clr1[SSR_S1_IDLE]) idle_armed_reg <= 1'b0;
    end
  end

  // data buffer: no reset on contents
  always_ff @(posedge i_sys_clk) begin
    if ((new_char && !overrun) || is_brk) rx_data_reg <= i_rx_evt.data;
    if (wr_data) tx_data_reg <= i_wdata;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) tx_pending_reg <= 1'b0;
    else if (wr_data) tx_pending_reg <= 1'b1;
    else if (i_tx_load_ack) tx_pending_reg <= 1'b0;
  end

  // control and rate registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl2_reg <= SSR_RST_CTRL;
      ctrl3_reg <= SSR_RST_CTRL;
      rate_reg  <= SSR_RST_RATE;
      fine_reg  <= SSR_RST_CTRL;
    end else begin
      if (i_wr && i_addr == SSR_OFF_CTRL2) ctrl2_reg <= i_wdata;
      if (i_wr && i_addr == SSR_OFF_CTRL3) ctrl3_reg[6:0] <= i_wdata[6:0];
      if (i_wr && i_addr == SSR_OFF_RATE) rate_reg <= {1'b0, i_wdata[6:0]};
      if (i_wr && i_addr == SSR_OFF_FINE) fine_reg <= i_wdata;
      if (is_brk) ctrl3_reg[SSR_C3_NINTH] <= 1'b0;
      else if (new_char && !overrun) ctrl3_reg[SSR_C3_NINTH] <= i_rx_evt.ninth;
    end
  end

  // read port: data one cycle after strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        SSR_OFF_STAT1: o_rdata <= stat1_reg;
        SSR_OFF_STAT2: o_rdata <= {6'h00, brk_reg, busy_reg};
        SSR_OFF_DATA:  o_rdata <= rx_data_reg;
        SSR_OFF_CTRL2: o_rdata <= ctrl2_reg;
        SSR_OFF_CTRL3: o_rdata <= ctrl3_reg;
        SSR_OFF_RATE:  o_rdata <= rate_reg;
        SSR_OFF_FINE:  o_rdata <= fine_reg;
        default:       o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ssr_rate_div u_rate (
    .i_sys_clk  (i_sys_clk),
    .i_srst     (i_srst),
    .i_psc_sel  (rate_reg[SSR_RT_PSC_LSB+:2]),
    .i_div_sel  (rate_reg[SSR_RT_DIV_LSB+:3]),
    .i_fine_div (fine_reg[7:5]),
    .i_fine_adj (fine_reg[4:0]),
    .o_tick     (o_rate_tick)
  );

  // break length: 11 or 12 bit times set by the receiver from these
  assign o_lin_break_select = rate_reg[SSR_RT_LIN];
  assign o_rx_enable        = ctrl2_reg[SSR_C2_RX_EN];
  assign o_tx_load_req      = tx_pending_reg;
  assign o_tx_data          = tx_data_reg;

  assign o_tx_irq  = (stat1_reg[SSR_S1_TXE] && ctrl2_reg[SSR_C2_EMPTY_IE])
                  || (stat1_reg[SSR_S1_TXC] && ctrl2_reg[SSR_C2_CMPL_IE]);
  assign o_rx_irq  = stat1_reg[SSR_S1_RXF] && ctrl2_reg[SSR_C2_FULL_IE];
  assign o_err_irq = (stat1_reg[SSR_S1_OVR] && ctrl3_reg[SSR_C3_OVR_IE])
                  || (stat1_reg[SSR_S1_NOISE] && ctrl3_reg[SSR_C3_NOISE_IE])
                  || (stat1_reg[SSR_S1_FRAME] && ctrl3_reg[SSR_C3_FRAME_IE])
                  || (stat1_reg[SSR_S1_PAR] && ctrl3_reg[SSR_C3_PAR_IE])
                  || (stat1_reg[SSR_S1_IDLE] && ctrl2_reg[SSR_C2_IDLE_IE]);
endmodule : ssr_top

// ===== dv/ssr_top_assertions.sv
`timescale 1ns/10ps
module ssr_top_chk
  import ssr_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_srst,
  input wire logic [SSR_AW-1:0] i_addr,
  input wire logic [7:0]        i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [7:0]        o_rdata,
  input wire logic              i_rx_evt_valid,
  input wire logic              i_tx_load_ack,
  input wire logic              o_tx_load_req,
  input wire logic              o_rate_tick,
  input wire logic              o_lin_break_select,
  input wire logic              o_rx_enable,
  input wire logic              o_tx_irq,
  input wire logic              o_rx_irq,
  input wire logic              o_err_irq
);
  logic [7:0] c2_reg;
  logic [7:0] c3_reg;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // shadow copies of the enable registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      c2_reg <= 8'h00;
      c3_reg <= 8'h00;
    end else if (i_wr && i_addr == SSR_OFF_CTRL2) begin
      c2_reg <= i_wdata;
    end else if (i_wr && i_addr == SSR_OFF_CTRL3) begin
      c3_reg <= i_wdata;
    end
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  tx_irq_gate_a: assert property (c2_reg[7:6] == 2'b00 |-> !o_tx_irq)
    else $error("tx irq without enable");
  rx_irq_gate_a: assert property (!c2_reg[5] |-> !o_rx_irq)
    else $error("rx irq without enable");
  err_irq_gate_a: assert property (!c2_reg[4] && c3_reg[3:0] == 4'h0 |-> !o_err_irq)
    else $error("error irq without enable");
  load_req_set_a: assert property (i_wr && i_addr == SSR_OFF_DATA |=> o_tx_load_req)
    else $error("data write did not queue byte");
  load_req_hold_a: assert property (o_tx_load_req && !i_tx_load_ack |=> o_tx_load_req)
    else $error("queued byte lost without handoff");
  lin_sel_a: assert property (i_wr && i_addr == SSR_OFF_RATE |=> o_lin_break_select == $past(i_wdata[6]))
    else $error("lin select not taken from write");
  rx_en_a: assert property (i_wr && i_addr == SSR_OFF_CTRL2 |=> o_rx_enable == $past(i_wdata[2]))
    else $error("rx enable not taken from write");
  tick_gap_a: assert property (o_rate_tick |=> !o_rate_tick [*8])
    else $error("rate ticks too close");
  cover property (o_tx_irq);
  cover property (o_err_irq);
  cover property (i_rx_evt_valid && o_rx_irq);
endmodule : ssr_top_chk

bind ssr_top ssr_top_chk i_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_evt_valid(i_rx_evt_valid), .i_tx_load_ack(i_tx_load_ack),
  .o_tx_load_req(o_tx_load_req), .o_rate_tick(o_rate_tick), .o_lin_break_select(o_lin_break_select),
  .o_rx_enable(o_rx_enable), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_err_irq(o_err_irq));

// ===== dv/ssr_far_node.sv
`timescale 1ns/10ps
module ssr_far_node
  import ssr_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_load_req,
  input  wire logic [7:0]  i_ack_delay,
  input  wire logic        i_cmd_valid,
  input  wire ssr_rx_evt_t i_cmd_evt,
  output logic             o_load_ack,
  output logic             o_shifting,
  output logic             o_evt_valid,
  output ssr_rx_evt_t      o_evt
);
  logic [7:0] wait_reg;
  logic [5:0] shift_reg;
  // shifter side: takes the byte after a delay, then shifts it out
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_load_ack <= 1'b0;
      o_shifting <= 1'b0;
      wait_reg   <= 8'h00;
      shift_reg  <= 6'h00;
    end else begin
      o_load_ack <= 1'b0;
      if (i_load_req && !o_load_ack && !o_shifting) begin
        if (wait_reg == i_ack_delay) begin
          o_load_ack <= 1'b1;
          o_shifting <= 1'b1;
          wait_reg   <= 8'h00;
          shift_reg  <= 6'h1E;
        end else begin
          wait_reg <= wait_reg + 8'h01;
        end
      end else if (o_shifting) begin
        if (shift_reg == 6'h00) begin
          o_shifting <= 1'b0;
        end else begin
          shift_reg <= shift_reg - 6'h01;
        end
      end
    end
  end
  // receive side: event only on command, pattern toggles otherwise
  always_ff @(posedge i_sys_clk) begin
    o_evt_valid <= i_cmd_valid && !i_srst;
    o_evt       <= i_cmd_valid ? i_cmd_evt : ~o_evt;
  end
endmodule : ssr_far_node

// ===== dv/tb_serial_status_rate_logic.sv
`timescale 1ns/10ps
module tb_serial_status_rate_logic;
  import ssr_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_srst    = 1'b1;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [3:0]  pl        = 4'h0;
  logic [4:0]  i_addr    = 5'h00;
  logic [7:0]  i_wdata   = 8'h00;
  logic [7:0]  ack_delay = 8'h14;
  logic [7:0]  seed      = 8'h30;
  logic [7:0]  b;
  ssr_rx_evt_t cmd_evt   = '0;
  ssr_rx_evt_t i_rx_evt;
  logic        i_rx_evt_valid, i_tx_load_ack, i_tx_shifting, o_tx_load_req, o_rate_tick;
  logic        o_lin_break_select, o_rx_enable, o_tx_irq, o_rx_irq, o_err_irq;
  logic [7:0]  o_rdata, o_tx_data;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          bpd_tab[4] = '{1, 3, 4, 13};

  ssr_top i_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_evt_valid(i_rx_evt_valid), .i_rx_evt(i_rx_evt),
    .i_rx_start_zero(pl[0]), .i_rx_false_start(pl[1]), .i_rx_idle_char(pl[2]), .i_rx_line_high(pl[3]),
    .i_rx_long_char(1'b0), .i_tx_load_ack(i_tx_load_ack), .i_tx_shifting(i_tx_shifting),
    .o_tx_load_req(o_tx_load_req), .o_tx_data(o_tx_data), .o_rate_tick(o_rate_tick),
    .o_lin_break_select(o_lin_break_select), .o_rx_enable(o_rx_enable), .o_tx_irq(o_tx_irq),
    .o_rx_irq(o_rx_irq), .o_err_irq(o_err_irq));
  ssr_far_node i_far (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_load_req(o_tx_load_req),
    .i_ack_delay(ack_delay), .i_cmd_valid(cmd_valid), .i_cmd_evt(cmd_evt), .o_load_ack(i_tx_load_ack),
    .o_shifting(i_tx_shifting), .o_evt_valid(i_rx_evt_valid), .o_evt(i_rx_evt));

  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  function automatic int exp_period(input int p, input int dv);
    return 64 * bpd_tab[p] * (1 << dv);
  endfunction : exp_period
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkn(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      failures++;
      $display("Error %0t: period %0d expected %0d", $time, got, exp);
    end
  endtask : chkn
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge i_sys_clk);
    pl[k] <= 1'b1;
    @(posedge i_sys_clk);
    pl <= 4'h0;
  endtask : pulse
  // f = {noise, frame, parity, break, ninth}
  task automatic send(input logic [4:0] f, input logic [7:0] v);
    @(posedge i_sys_clk);
    cmd_evt   <= {1'b1, f, v};
    cmd_valid <= 1'b1;
    @(posedge i_sys_clk);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask : send
  task automatic period(input int e);
    int n;
    n = 0;
    do begin @(posedge i_sys_clk); #1; end while (!o_rate_tick);
    do begin @(posedge i_sys_clk); #1; n++; end while (!o_rate_tick);
    chkn(n, e);
  endtask : period
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    rd(SSR_OFF_STAT1, 8'hC0);
    rd(SSR_OFF_STAT2, 8'h00);
    rd(SSR_OFF_RATE, 8'h00);
    rd(5'h1F, 8'h00);
    b = seed;
    wr(SSR_OFF_CTRL2, 8'h80);
    chk({7'h00, o_tx_irq}, 8'h01);
    rd(SSR_OFF_STAT1, 8'hC0);
    wr(SSR_OFF_DATA, b);
    rd(SSR_OFF_STAT1, 8'h00);
    chk({7'h00, o_tx_irq}, 8'h00);
    chk(o_tx_data, b);
    chk({7'h00, o_tx_load_req}, 8'h01);
    do begin @(posedge i_sys_clk); #1; end while (!i_tx_load_ack);
    rd(SSR_OFF_STAT1, 8'h80);
    chk({7'h00, o_tx_load_req}, 8'h00);
    chk({7'h00, o_tx_irq}, 8'h01);
    repeat (40) @(posedge i_sys_clk);
    rd(SSR_OFF_STAT1, 8'hC0);
    wr(SSR_OFF_CTRL2, 8'h44);
    chk({7'h00, o_tx_irq}, 8'h01);
    wr(SSR_OFF_CTRL2, 8'h24);
    chk({7'h00, o_rx_enable}, 8'h01);
    pulse(2);
    rd(SSR_OFF_STAT1, 8'hC0);
    seed = lfsr(seed);
    b = seed;
    send(5'h00, b);
    rd(SSR_OFF_STAT1, 8'hE0);
    chk({7'h00, o_rx_irq}, 8'h01);
    send(5'h00, ~b);
    rd(SSR_OFF_STAT1, 8'hE8);
    rd(SSR_OFF_DATA, b);
    rd(SSR_OFF_STAT1, 8'hC0);
    chk({7'h00, o_rx_irq}, 8'h00);
    send(5'h00, b);
    rd(SSR_OFF_STAT1, 8'hE0);
    send(5'h00, ~b);
    rd(SSR_OFF_DATA, b);
    rd(SSR_OFF_STAT1, 8'hC8);
    wr(SSR_OFF_CTRL3, 8'h08);
    chk({7'h00, o_err_irq}, 8'h01);
    rd(SSR_OFF_DATA, b);
    rd(SSR_OFF_STAT1, 8'hC0);
    chk({7'h00, o_err_irq}, 8'h00);
    pulse(2);
    rd(SSR_OFF_STAT1, 8'hD0);
    wr(SSR_OFF_CTRL2, 8'h34);
    chk({7'h00, o_err_irq}, 8'h01);
    rd(SSR_OFF_DATA, b);
    pulse(2);
    rd(SSR_OFF_STAT1, 8'hC0);
    chk({7'h00, o_err_irq}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      send(5'(4 << k), b);
      wr(SSR_OFF_CTRL3, 8'h0F ^ 8'(1 << k));
      chk({7'h00, o_err_irq}, 8'h00);
      wr(SSR_OFF_CTRL3, 8'(1 << k));
      chk({7'h00, o_err_irq}, 8'h01);
      rd(SSR_OFF_STAT1, 8'hE0 | 8'(1 << k));
      rd(SSR_OFF_DATA, b);
      rd(SSR_OFF_STAT1, 8'hC0);
    end
    wr(SSR_OFF_CTRL3, 8'h00);
    pulse(3);
    send(5'h0B, 8'h00);
    rd(SSR_OFF_STAT2, 8'h02);
    rd(SSR_OFF_STAT1, 8'hE2);
    rd(SSR_OFF_CTRL3, 8'h00);
    rd(SSR_OFF_STAT2, 8'h02);
    rd(SSR_OFF_DATA, 8'h00);
    rd(SSR_OFF_STAT2, 8'h00);
    send(5'h0A, 8'h00);
    rd(SSR_OFF_STAT2, 8'h00);
    pulse(0);
    rd(SSR_OFF_STAT2, 8'h01);
    pulse(1);
    rd(SSR_OFF_STAT2, 8'h00);
    pulse(0);
    pulse(2);
    rd(SSR_OFF_STAT2, 8'h00);
    wr(SSR_OFF_RATE, seed);
    rd(SSR_OFF_RATE, seed & 8'h7F);
    chk({7'h00, o_lin_break_select}, {7'h00, seed[6]});
    for (int p = 0; p < 4; p++) begin
      seed = lfsr(seed);
      wr(SSR_OFF_RATE, {2'b00, 2'(p), 3'b000, seed[0]});
      period(exp_period(p, int'(seed[0])));
    end
    complete_run();
  end
endmodule : tb_serial_status_rate_logic
